// >>> src/sps_sequencer.sv
// Four-phase stepper sequencer with full and half step modes.
// Assumes step and direction inputs are synchronous and debounced.
// How it works
// - Power-on starts in single-winding full-step mode.
// - Half-step mode cycles through eight patterns.
// - Clockwise full-step order is A, B, C, D.
// - Clockwise half-step order A AB B BC...DA.
// - Direction high clockwise, low counter-clockwise.
// - Outputs advance on step falling edge.
// - Direction rise during step selects half-step.
// - Direction fall during step selects full-step.
// - Leaving half mode on pair: half step.
// - All four phases held low until first step.
// - Step ignored about 20 ms after power-up.
// - Supports step rates to 25000 per second.
// - Position held indefinitely without strobes.
// - Four separate active-high winding outputs.
// - Reset taken from the rst_b_i pin through a two-stage synchronizer.
`timescale 1ns/1ps
`default_nettype none
module sps_sequencer
    import sps_pkg::*;
#(
    parameter int INHIBIT_CNT = INHIBIT_CYCLES
)
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    // Host control
    input  wire logic step_i,
    input  wire logic dir_i,
    // Winding drives
    output logic      phase1_o,
    output logic      phase2_o,
    output logic      phase3_o,
    output logic      phase4_o
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    // The reset pin may be tied high; the power-on flops below then start
    // from their power-up state, which a later release also establishes.
    logic [1:0] rst_sync_r;
    wire  logic rst_b = rst_sync_r[1];

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    // ------------------------------------------------------------------
    // Power-up step inhibit
    // ------------------------------------------------------------------
    localparam int CW = $clog2(INHIBIT_CNT + 1);
    logic [CW-1:0] inh_cnt_r;
    wire  logic    inhibit = (inh_cnt_r != CW'(INHIBIT_CNT));

    always_ff @(posedge clk_i or negedge rst_b)
    begin
        if (!rst_b)
            inh_cnt_r <= '0;
        else if (inhibit)
            inh_cnt_r <= inh_cnt_r + CW'(1);
    end

    // ------------------------------------------------------------------
    // Strobe tracking
    // ------------------------------------------------------------------
    logic step_q_r;
    logic dir_q_r;
    logic armed_r;
    logic toggled_r;
    logic rose_last_r;

    wire logic step_rise = step_i & ~step_q_r & ~inhibit;
    wire logic step_fall = ~step_i & step_q_r & armed_r;
    wire logic dir_edge  = armed_r & step_i & (dir_i != dir_q_r);

    always_ff @(posedge clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            step_q_r    <= 1'b0;
            dir_q_r     <= 1'b0;
            armed_r     <= 1'b0;
            toggled_r   <= 1'b0;
            rose_last_r <= 1'b0;
        end
        else
        begin
            step_q_r <= step_i;
            dir_q_r  <= dir_i;
            if (step_rise)
            begin
                armed_r   <= 1'b1;
                toggled_r <= 1'b0;
            end
            else if (step_fall)
                armed_r <= 1'b0;
            if (dir_edge)
            begin
                toggled_r   <= 1'b1;
                rose_last_r <= dir_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // Mode and position
    // ------------------------------------------------------------------
    sps_mode_e        mode_r;
    logic [POS_W-1:0] pos_r;
    logic             started_r;
    logic             realign_r;

    // Half mode moves by one eighth; full mode by two, but a pending
    // realignment moves one eighth to land back on a single winding.
    wire logic             half_move = (mode_r == SPS_HALF) | realign_r;
    wire logic [POS_W-1:0] stride    = half_move ? 3'h1 : 3'h2;
    wire logic [POS_W-1:0] pos_cw    = pos_r + stride;
    wire logic [POS_W-1:0] pos_ccw   = pos_r - stride;
    wire logic             do_step   = step_fall & ~toggled_r
                                       & ~dir_edge;
    wire logic             do_mode   = step_fall & (toggled_r | dir_edge);
    wire logic             to_half   = dir_edge ? dir_i : rose_last_r;
    wire logic [POS_W-1:0] pos_nxt   = do_step ? (dir_i ? pos_cw : pos_ccw)
                                               : pos_r;

    always_ff @(posedge clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_r    <= SPS_FULL;
            pos_r     <= '0;
            started_r <= 1'b0;
            realign_r <= 1'b0;
        end
        else
        begin
            pos_r <= pos_nxt;
            if (step_fall)
                started_r <= 1'b1;
            if (do_mode)
            begin
                mode_r    <= to_half ? SPS_HALF : SPS_FULL;
                realign_r <= ~to_half & pos_r[0];
            end
            else if (do_step)
                realign_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Winding outputs
    // ------------------------------------------------------------------
    // The lookup is one cycle behind the position and the outputs one behind it;
    // each update therefore lands three clocks after the falling edge, far inside a 40 us step.
    logic [3:0] pat;

    sps_pattern_rom u_rom (
        .clk_i   (clk_i),
        .rst_b_i (rst_b),
        .pos_i   (pos_r),
        .en_i    (started_r),
        .pat_o   (pat)
    );

    always_ff @(posedge clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            phase1_o <= 1'b0;
            phase2_o <= 1'b0;
            phase3_o <= 1'b0;
            phase4_o <= 1'b0;
        end
        else
        begin
            phase1_o <= pat[0];
            phase2_o <= pat[1];
            phase3_o <= pat[2];
            phase4_o <= pat[3];
        end
    end

endmodule
`default_nettype wire

// >>> src/sps_pkg.sv
// Constants for the four-phase stepper sequencer.
// Assumes a 20 MHz system clock.
package sps_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ          = 20000000;
    localparam int INHIBIT_MS      = 20;
    localparam int INHIBIT_CYCLES  = CLK_HZ / 1000 * INHIBIT_MS;
    localparam int SEQ_LEN         = 8;
    localparam int POS_W           = 3;

    // ------------------------------------------------------------------
    // Winding patterns, bit 0 is the first phase
    // ------------------------------------------------------------------
    localparam logic [3:0] PAT_OFF = 4'h0;

    typedef enum logic {SPS_FULL, SPS_HALF} sps_mode_e;

endpackage

// >>> src/sps_pattern_rom.sv
// Registered lookup from eighth-step position to winding pattern.
// Assumes the caller holds the position stable between steps.
`timescale 1ns/1ps
`default_nettype none
module sps_pattern_rom
    import sps_pkg::*;
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    // Lookup
    input  wire logic [POS_W-1:0] pos_i,
    input  wire logic             en_i,
    output logic      [3:0]       pat_o
);

    // ------------------------------------------------------------------
    // Table
    // ------------------------------------------------------------------
    // Even positions hold one winding, odd positions two adjacent ones.
    function automatic logic [3:0] pat_of(input logic [POS_W-1:0] p);
        case (p)
            3'h0:    pat_of = 4'h1;
            3'h1:    pat_of = 4'h3;
            3'h2:    pat_of = 4'h2;
            3'h3:    pat_of = 4'h6;
            3'h4:    pat_of = 4'h4;
            3'h5:    pat_of = 4'hc;
            3'h6:    pat_of = 4'h8;
            3'h7:    pat_of = 4'h9;
            default: pat_of = 4'h1;
        endcase
    endfunction

    wire logic [3:0] pat_nxt = en_i ? pat_of(pos_i) : PAT_OFF;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            pat_o <= PAT_OFF;
        else
            pat_o <= pat_nxt;
    end

endmodule
`default_nettype wire

// >>> test/sps_asserts.sv
// Port checker for the stepper sequencer, bound to its top module.
// Assumes strobes respect the host timing limits.
`timescale 1ns/1ps
`default_nettype none
module sps_asserts #(
    parameter int INHIBIT_CNT = 20
)
(
    // Watched ports
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic step_i,
    input wire logic dir_i,
    input wire logic phase1_o,
    input wire logic phase2_o,
    input wire logic phase3_o,
    input wire logic phase4_o
);
    logic [3:0] pat;
    logic       tog_r;
    logic       on_r;
    int         cnt_r;
    assign pat = {phase4_o, phase3_o, phase2_o, phase1_o};
    function automatic logic [3:0] rot(logic [3:0] p, logic cw);
        return cw ? {p[2:0], p[3]} : {p[0], p[3:1]};
    endfunction
    always_ff @(posedge clk_i or negedge rst_b_i)
        if (!rst_b_i)
        begin
            tog_r <= 1'b0;
            on_r  <= 1'b0;
            cnt_r <= 0;
        end
        else
        begin
            tog_r <= step_i && !$rose(step_i) && (tog_r || $changed(dir_i));
            on_r  <= on_r || pat != 4'h0;
            cnt_r <= cnt_r + int'(cnt_r <= INHIBIT_CNT);
        end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    sequence s_quiet; ##1 $stable(pat) [*5]; endsequence
    // The step low is first sampled at the fall edge; the position, the
    // lookup and the output flops then take one edge each.
    sequence s_move; ##3 $changed(pat); endsequence
    property p_dark; $rose(rst_b_i) |-> (pat == 4'h0) [*8]; endproperty
    a_dark: assert property (p_dark) else $error("lit after reset");
    property p_shape; pat inside {0, 1, 3, 2, 6, 4, 12, 8, 9}; endproperty
    a_shape: assert property (p_shape) else $error("bad pattern");
    property p_cause;
        $changed(pat) |-> $past(step_i, 4) && !$past(step_i, 3);
    endproperty
    a_cause: assert property (p_cause) else $error("stray change");
    property p_first;
        $changed(pat) && !on_r |-> pat == ($past(dir_i, 4) ? 4'h2 : 4'h8);
    endproperty
    a_first: assert property (p_first) else $error("bad first");
    property p_dir;
        $changed(pat) && on_r |-> pat == rot($past(pat), $past(dir_i, 4))
            || pat == ($past(pat) & rot($past(pat), $past(dir_i, 4)))
            || pat == ($past(pat) | rot($past(pat), $past(dir_i, 4)));
    endproperty
    a_dir: assert property (p_dir) else $error("bad order");
    property p_inhibit; $fell(step_i) && cnt_r < INHIBIT_CNT |-> s_quiet;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("early");
    property p_still; $fell(step_i) && tog_r |-> s_quiet; endproperty
    a_still: assert property (p_still) else $error("mode moved");
    property p_moves;
        $fell(step_i) && !tog_r && cnt_r > INHIBIT_CNT |-> s_move;
    endproperty
    a_moves: assert property (p_moves) else $error("no step");
endmodule
bind sps_sequencer sps_asserts #(.INHIBIT_CNT(INHIBIT_CNT)) u_sps_asserts (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .step_i(step_i), .dir_i(dir_i),
    .phase1_o(phase1_o), .phase2_o(phase2_o), .phase3_o(phase3_o),
    .phase4_o(phase4_o));
`default_nettype wire

// >>> test/sps_host_model.sv
// Host model issuing step and direction strobes.
// Assumes calls come one at a time; drives just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module sps_host_model (
    // Strobe side
    input  wire logic clk_i,
    output logic      step_o,
    output logic      dir_o
);
    initial
    begin
        step_o = 1'b0;
        dir_o  = 1'b1;
    end
    task automatic strobe(input bit dir, input bit tog, input int hi,
                          input int gap);
        @(posedge clk_i);
        dir_o <= dir;
        repeat (40) @(posedge clk_i);
        step_o <= 1'b1;
        repeat (hi / 2) @(posedge clk_i);
        dir_o <= tog ? !dir : dir;
        repeat (hi / 2 + 40) @(posedge clk_i);
        step_o <= 1'b0;
        repeat (gap) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// >>> test/sps_sequencer_bench.sv
// Self-checking bench for the stepper sequencer.
// Assumes the host model paces every strobe.
`timescale 1ns/1ps
`default_nettype none
module sps_sequencer_bench;
    localparam int INH = 200;
    logic       clk_i = 1'b0;
    logic       rst_b_i = 1'b0;
    wire logic  step_i;
    wire logic  dir_i;
    wire logic [3:0] ph;
    int         failures = 0;
    int         cmp_count = 0;
    int         pos = 0;
    bit         half = 0;
    bit         realign = 0;
    bit         on = 0;
    always #25 clk_i = ~clk_i;
    sps_sequencer #(.INHIBIT_CNT(INH)) u_sps_sequencer (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .step_i(step_i), .dir_i(dir_i),
        .phase1_o(ph[0]), .phase2_o(ph[1]), .phase3_o(ph[2]),
        .phase4_o(ph[3]));
    sps_host_model u_sps_host_model (.clk_i(clk_i), .step_o(step_i),
        .dir_o(dir_i));
    function automatic logic [3:0] exp_pat(input int p);
        return (4'h1 << p / 2) | (p % 2 ? 4'h1 << (p + 1) / 2 % 4 : 4'h0);
    endfunction
    task automatic check(input logic [3:0] exp);
        cmp_count++;
        if (ph !== exp)
        begin
            failures++;
            $display("[ERR] phases exp %h got %h", exp, ph);
        end
    endtask
    task automatic step(input bit cw, input bit tog);
        int h;
        h = 200 + $urandom % 60;
        u_sps_host_model.strobe(cw, tog, h, tog ? 1000 : 600 + h);
        if (tog)
        begin
            realign = cw && pos % 2 == 1;
            half = !cw;
        end
        else
        begin
            pos = (pos + (cw ? 1 : 7) * (half || realign ? 1 : 2)) % 8;
            realign = 0;
            on = 1;
        end
        check(on ? exp_pat(pos) : 4'h0);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        void'($urandom(32'h233f4829));
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        u_sps_host_model.strobe(1'b1, 1'b0, 2, INH);
        check(4'h0);
        step(1'b1, 1'b0);
        repeat (3) step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b1);
        repeat (9) step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b0);
        repeat (24) step($urandom % 2, $urandom % 4 == 0);
        finish_test();
    end
    initial
    begin
        repeat (80000) @(posedge clk_i);
        failures++;
        finish_test();
    end
endmodule
`default_nettype wire
